// ---- rtl/msa_pkg.sv ----
// Constants for the stream-2 attribute register bank: offsets, fields, reset values.
// Assumes an APB master on a 32-bit data bus and one 100 MHz clock.
// How it works
// - Sixteen-bit count of clocks from hsync lead edge to first active pixel.
// - Sixteen-bit count of lines from vsync lead edge to first active line.
// - Attribute byte A: sync clock, format, range, colorimetry, bit depth fields.
// - Attribute byte B: interlace even flag, stereo field, bits 7:3 reserved.
// - Asynchronous mode uses a computed M, never written into the register.
// - Asynchronous mode never writes a computed N back into the register.
// - Transfer unit size resets to 64.
// - Bit 0 of the transfer unit size ignores writes; the size stays even.
package msa_pkg;
  localparam logic [11:0] OFS_HSTART = 12'h51c;
  localparam logic [11:0] OFS_VSTART = 12'h520;
  localparam logic [11:0] OFS_ATTR_A = 12'h524;
  localparam logic [11:0] OFS_ATTR_B = 12'h528;
  localparam logic [11:0] OFS_MVAL = 12'h52c;
  localparam logic [11:0] OFS_TU = 12'h530;
  localparam logic [11:0] OFS_NVAL = 12'h534;
  localparam int START_W = 16;
  localparam int ATTR_W = 8;
  localparam int RATIO_W = 24;
  localparam int TU_W = 7;
  localparam int ATTR_B_USED_W = 3;
  localparam logic [6:0] TU_RESET = 7'h40;
  localparam logic [15:0] START_RESET = 16'h0000;
  localparam logic [7:0] ATTR_RESET = 8'h00;
  localparam logic [23:0] RATIO_RESET = 24'h000000;
  localparam int SYNC_CLK_BIT = 0;
  localparam int FMT_LSB = 1;
  localparam int RANGE_BIT = 3;
  localparam int COLOR_BIT = 4;
  localparam int DEPTH_LSB = 5;
  localparam int INTERLACE_BIT = 0;
  localparam int STEREO_LSB = 1;
  typedef enum logic [2:0] {
    MSA_SEL_HSTART, MSA_SEL_VSTART, MSA_SEL_ATTR_A, MSA_SEL_ATTR_B,
    MSA_SEL_MVAL, MSA_SEL_TU, MSA_SEL_NVAL, MSA_SEL_NONE
  } msa_sel_t;
endpackage

// ---- rtl/msa_ratio_sel.sv ----
// Chooses the M and N values that the framing logic inserts into the main stream.
// Assumes the computed values come from clock-recovery logic on the same clock.
`timescale 1ns/1ps
module msa_ratio_sel (
  input wire logic i_sync_clk,
  input wire logic [msa_pkg::RATIO_W-1:0] i_reg_m,
  input wire logic [msa_pkg::RATIO_W-1:0] i_reg_n,
  input wire logic [msa_pkg::RATIO_W-1:0] i_calc_m,
  input wire logic [msa_pkg::RATIO_W-1:0] i_calc_n,
  output logic [msa_pkg::RATIO_W-1:0] o_m,
  output logic [msa_pkg::RATIO_W-1:0] o_n
);
  import msa_pkg::*;
  // Computed values go only to the stream, never back into the registers.
  assign o_m = i_sync_clk ? i_reg_m : i_calc_m;
  assign o_n = i_sync_clk ? i_reg_n : i_calc_n;
endmodule

// ---- rtl/msa_regs.sv ----
// Stream-2 attribute register bank with an APB slave port.
// Assumes an APB master on i_mclk; framing logic reads the o_ fields.
`timescale 1ns/1ps
module msa_regs (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [msa_pkg::RATIO_W-1:0] i_calc_m,
  input wire logic [msa_pkg::RATIO_W-1:0] i_calc_n,
  output logic [msa_pkg::START_W-1:0] o_hstart,
  output logic [msa_pkg::START_W-1:0] o_vstart,
  output logic [msa_pkg::ATTR_W-1:0] o_attr_a,
  output logic [msa_pkg::ATTR_W-1:0] o_attr_b,
  output logic o_sync_clk,
  output logic [1:0] o_comp_format,
  output logic o_dyn_range,
  output logic o_ycbcr_color,
  output logic [2:0] o_bit_depth,
  output logic o_interlace_even,
  output logic [1:0] o_stereo,
  output logic [msa_pkg::TU_W-1:0] o_tu_size,
  output logic [msa_pkg::RATIO_W-1:0] o_stream_m,
  output logic [msa_pkg::RATIO_W-1:0] o_stream_n
);
  import msa_pkg::*;

  logic rst_meta;
  logic rst_sync;
  logic [15:0] hstart;
  logic [15:0] vstart;
  logic [7:0] attr_a;
  logic [7:0] attr_b;
  logic [23:0] mval;
  logic [23:0] nval;
  logic [6:0] tu;
  msa_sel_t sel;
  logic wr_en;
  logic rd_en;
  logic [31:0] next_rdata;
  logic [31:0] merged_h;
  logic [31:0] merged_v;
  logic [31:0] merged_m;
  logic [31:0] merged_n;

  function automatic msa_sel_t decode(input logic [11:0] addr);
    case (addr)
      OFS_HSTART: decode = MSA_SEL_HSTART;
      OFS_VSTART: decode = MSA_SEL_VSTART;
      OFS_ATTR_A: decode = MSA_SEL_ATTR_A;
      OFS_ATTR_B: decode = MSA_SEL_ATTR_B;
      OFS_MVAL: decode = MSA_SEL_MVAL;
      OFS_TU: decode = MSA_SEL_TU;
      OFS_NVAL: decode = MSA_SEL_NVAL;
      default: decode = MSA_SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge so that partial APB writes touch only their lanes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign sel = decode(i_paddr);
  assign wr_en = i_psel && i_penable && i_pwrite && (sel != MSA_SEL_NONE);
  assign rd_en = i_psel && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && (sel == MSA_SEL_NONE);

  // Lane-merged write words; a function result cannot be part-selected directly.
  assign merged_h = merge({16'h0000, hstart}, i_pwdata, i_pstrb);
  assign merged_v = merge({16'h0000, vstart}, i_pwdata, i_pstrb);
  assign merged_m = merge({8'h00, mval}, i_pwdata, i_pstrb);
  assign merged_n = merge({8'h00, nval}, i_pwdata, i_pstrb);

  always_ff @(posedge i_mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      hstart <= START_RESET;
      vstart <= START_RESET;
      attr_a <= ATTR_RESET;
      attr_b <= ATTR_RESET;
      mval <= RATIO_RESET;
      nval <= RATIO_RESET;
    end else if (wr_en) begin
      case (sel)
        MSA_SEL_HSTART: hstart <= merged_h[15:0];
        MSA_SEL_VSTART: vstart <= merged_v[15:0];
        MSA_SEL_ATTR_A: attr_a <= i_pstrb[0] ? i_pwdata[7:0] : attr_a;
        MSA_SEL_ATTR_B: attr_b <= i_pstrb[0] ? {4'h0, i_pwdata[3:0] & 4'h7} : attr_b;
        MSA_SEL_MVAL: mval <= merged_m[23:0];
        MSA_SEL_NVAL: nval <= merged_n[23:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      tu <= TU_RESET;
    end else if (wr_en && sel == MSA_SEL_TU && i_pstrb[0]) begin
      tu <= {i_pwdata[6:1], tu[0]};
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    case (sel)
      MSA_SEL_HSTART: next_rdata = {16'h0000, hstart};
      MSA_SEL_VSTART: next_rdata = {16'h0000, vstart};
      MSA_SEL_ATTR_A: next_rdata = {24'h000000, attr_a};
      MSA_SEL_ATTR_B: next_rdata = {24'h000000, attr_b};
      MSA_SEL_MVAL: next_rdata = {8'h00, mval};
      MSA_SEL_TU: next_rdata = {25'h0000000, tu};
      MSA_SEL_NVAL: next_rdata = {8'h00, nval};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data is registered in the setup cycle so it is valid in the access cycle.
  always_ff @(posedge i_mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      o_prdata <= 32'h00000000;
    end else if (rd_en && !i_penable) begin
      o_prdata <= next_rdata;
    end
  end

  assign o_hstart = hstart;
  assign o_vstart = vstart;
  assign o_attr_a = attr_a;
  assign o_attr_b = attr_b;
  assign o_sync_clk = attr_a[SYNC_CLK_BIT];
  assign o_comp_format = attr_a[FMT_LSB +: 2];
  assign o_dyn_range = attr_a[RANGE_BIT];
  assign o_ycbcr_color = attr_a[COLOR_BIT];
  assign o_bit_depth = attr_a[DEPTH_LSB +: 3];
  assign o_interlace_even = attr_b[INTERLACE_BIT];
  assign o_stereo = attr_b[STEREO_LSB +: 2];
  assign o_tu_size = tu;

  msa_ratio_sel u_ratio (
    .i_sync_clk(attr_a[SYNC_CLK_BIT]),
    .i_reg_m(mval),
    .i_reg_n(nval),
    .i_calc_m(i_calc_m),
    .i_calc_n(i_calc_n),
    .o_m(o_stream_m),
    .o_n(o_stream_n)
  );

  tu_even_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    tu[0] == 1'b0) else $error("transfer unit size became odd");
  tu_write_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    (wr_en && sel == MSA_SEL_TU && i_pstrb[0]) |=> tu == {$past(i_pwdata[6:1]), 1'b0})
    else $error("transfer unit size not updated");
  tu_reset_a: assert property (@(posedge i_mclk)
    $rose(rst_sync) |-> tu == 7'h40) else $error("transfer unit size reset wrong");
  m_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    !(wr_en && sel == MSA_SEL_MVAL) |=> $stable(mval)) else $error("M changed without write");
  n_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    !(wr_en && sel == MSA_SEL_NVAL) |=> $stable(nval)) else $error("N changed without write");
  m_select_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    o_stream_m == (attr_a[0] ? mval : i_calc_m)) else $error("stream M source wrong");
  n_select_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    o_stream_n == (attr_a[0] ? nval : i_calc_n)) else $error("stream N source wrong");
  hstart_rb_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    (wr_en && sel == MSA_SEL_HSTART && i_pstrb == 4'hf) |=> hstart == $past(i_pwdata[15:0]))
    else $error("hsync start not stored");
  vstart_rb_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    (wr_en && sel == MSA_SEL_VSTART && i_pstrb == 4'hf) |=> vstart == $past(i_pwdata[15:0]))
    else $error("vsync start not stored");
  attr_b_rsvd_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    attr_b[7:3] == 5'h00) else $error("attribute B reserved bits set");
  attr_a_wr_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    (wr_en && sel == MSA_SEL_ATTR_A && i_pstrb[0]) |=> o_bit_depth == $past(i_pwdata[7:5]))
    else $error("bit depth not stored");
  rd_back_a: assert property (@(posedge i_mclk) disable iff (!rst_sync)
    (i_psel && !i_penable && !i_pwrite && sel == MSA_SEL_VSTART) |=> o_prdata == {16'h0, vstart})
    else $error("readback mismatch");

  wr_tu_c: cover property (@(posedge i_mclk) wr_en && sel == MSA_SEL_TU);
  async_c: cover property (@(posedge i_mclk) !attr_a[0] && o_stream_m != mval);
  err_c: cover property (@(posedge i_mclk) o_pslverr);
endmodule

// ---- bench/tb_mst_stream2_attribute_regs.sv ----
// Self-checking bench for the stream-2 attribute register bank.
// Assumes msa_regs with a zero-wait APB slave on a 100 MHz clock.
`timescale 1ns/1ps
module tb_mst_stream2_attribute_regs;
  import msa_pkg::*;
  logic i_mclk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic [3:0] i_pstrb = 4'hf;
  logic o_pready, o_pslverr, se, o_sync_clk, o_dyn_range, o_ycbcr_color, o_interlace_even;
  logic [23:0] i_calc_m = 24'h123456, i_calc_n = 24'habcdef, o_stream_m, o_stream_n;
  logic [15:0] o_hstart, o_vstart;
  logic [7:0] o_attr_a, o_attr_b;
  logic [1:0] o_comp_format, o_stereo;
  logic [2:0] o_bit_depth;
  logic [6:0] o_tu_size;
  int err_count = 0, samples_checked = 0;
  msa_regs u_msa_regs (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_calc_m(i_calc_m), .i_calc_n(i_calc_n), .o_hstart(o_hstart), .o_vstart(o_vstart),
    .o_attr_a(o_attr_a), .o_attr_b(o_attr_b), .o_sync_clk(o_sync_clk),
    .o_comp_format(o_comp_format), .o_dyn_range(o_dyn_range), .o_ycbcr_color(o_ycbcr_color),
    .o_bit_depth(o_bit_depth), .o_interlace_even(o_interlace_even), .o_stereo(o_stereo),
    .o_tu_size(o_tu_size), .o_stream_m(o_stream_m), .o_stream_n(o_stream_n));
  always #5 i_mclk = ~i_mclk;
  task automatic close_out();
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1, "pready never came");
    rd = o_prdata;
    se = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // Let the register updates of the access edge settle before callers look.
    @(negedge i_mclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "readback");
    chk(se, 1'b0, "slave error on mapped read");
  endtask
  task automatic t_reset_vals();
    logic [11:0] ofs [7] = '{OFS_HSTART, OFS_VSTART, OFS_ATTR_A, OFS_ATTR_B, OFS_MVAL,
      OFS_TU, OFS_NVAL};
    foreach (ofs[i]) rdchk(ofs[i], (ofs[i] == OFS_TU) ? 32'h40 : 32'h0);
    chk(o_tu_size, 7'h40, "unit size at reset");
  endtask
  task automatic t_starts();
    apb(1'b1, OFS_HSTART, 32'hffffa5c3);
    apb(1'b1, OFS_VSTART, 32'h12348001);
    rdchk(OFS_HSTART, 32'h0000a5c3);
    chk(o_hstart, 16'ha5c3, "hstart out");
    rdchk(OFS_VSTART, 32'h00008001);
    chk(o_vstart, 16'h8001, "vstart out");
  endtask
  task automatic t_attr();
    apb(1'b1, OFS_ATTR_A, 32'h000000b5);
    rdchk(OFS_ATTR_A, 32'hb5);
    chk({o_bit_depth, o_ycbcr_color, o_dyn_range, o_comp_format, o_sync_clk}, 8'hb5, "a");
    apb(1'b1, OFS_ATTR_B, 32'h000000ff);
    rdchk(OFS_ATTR_B, 32'h07);
    chk({o_stereo, o_interlace_even}, 3'b111, "b fields");
    apb(1'b1, OFS_ATTR_B, 32'h00000002);
    chk({o_attr_b, o_stereo, o_interlace_even}, 11'h012, "b fields");
  endtask
  task automatic t_ratio();
    apb(1'b1, OFS_MVAL, 32'hfedcba98);
    apb(1'b1, OFS_NVAL, 32'h00654321);
    chk({o_stream_m, o_stream_n}, 48'hdcba98654321, "sync ratio");
    apb(1'b1, OFS_ATTR_A, 32'h000000b4);
    chk({o_stream_m, o_stream_n}, 48'h123456abcdef, "async ratio");
    i_calc_m <= 24'h0f0f0f;
    i_calc_n <= 24'h707070;
    repeat (3) @(posedge i_mclk);
    chk({o_stream_m, o_stream_n}, 48'h0f0f0f707070, "async follows");
    rdchk(OFS_MVAL, 32'h00dcba98);
    rdchk(OFS_NVAL, 32'h00654321);
  endtask
  task automatic t_tu();
    apb(1'b1, OFS_TU, 32'h00000021);
    rdchk(OFS_TU, 32'h20);
    chk(o_tu_size, 7'h20, "unit size out");
    apb(1'b1, OFS_TU, 32'h0000002f);
    rdchk(OFS_TU, 32'h2e);
  endtask
  task automatic t_unmapped();
    apb(1'b1, 12'h538, 32'hffffffff);
    chk(se, 1'b1, "unmapped write error");
    apb(1'b0, 12'h538, 32'h0);
    chk({se, rd}, 33'h100000000, "unmapped read");
    rdchk(OFS_HSTART, 32'h0000a5c3);
  endtask
  initial begin
    repeat (5000) @(posedge i_mclk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_reset_vals();
    t_starts();
    t_attr();
    t_ratio();
    t_tu();
    t_unmapped();
    close_out();
  end
endmodule
